// File: src/bwh_bridge_window_regs.sv
`timescale 1ns/100ps
`include "bwh_defines.svh"

// What this block does
// RULE1: Upper limit word at 2Ch holds window top bits 63:32, fully writable.
// RULE2: That upper limit word resets to all zeros.
// RULE3: I/O floor upper half at 30h holds base bits 31:16, writable.
// RULE4: I/O top upper half at 32h holds top bits 31:16, writable.
// RULE5: Both I/O upper halves reset to zero.
// RULE6: Capability pointer at 34h always reads 50h; writes do nothing.
// RULE7: Interrupt line byte at 3Ch is plain storage steering nothing.
// RULE8: Interrupt line byte resets to FFh, meaning unassigned.
// RULE9: Interrupt pin byte at 3Dh reads 01h, meaning INTA, read-only.
// RULE10: Port interrupts go upstream on the primary side, never remapped by device.
// RULE11: Bridge control word at 3Eh exists and resets to zero; here bits 6:0 read i_bctl_low, which this block does not reset.
// RULE12: Bridge control bits 15:12 read zero and ignore writes.
// RULE13: Bridge control discard timer bits 11:8 are hardwired zero.
// RULE14: Bridge control back-to-back enable bit 7 is hardwired zero.
// RULE15: Prefetch top is lower limit bits 31:20, ones below, upper word above.
// RULE16: Forward only when address lies inclusively between base and top.
module bwh_bridge_window_regs
  import bwh_pkg::*;
#(
  parameter int CFG_AW = 8
) (
  input  wire logic           i_clk_sys,
  input  wire logic           i_rst,
  input  wire bwh_cfg_req_t   i_cfg,
  output logic                o_cfg_ack,
  output logic                o_cfg_hit,
  output logic [31:0]         o_cfg_rdata,
  input  wire bwh_lower_win_t i_lower,
  input  wire logic [6:0]     i_bctl_low,
  input  wire bwh_fwd_req_t   i_fwd,
  output logic                o_fwd_done,
  output logic                o_fwd_hit,
  output logic [63:0]         o_pref_top,
  output logic [31:0]         o_io_base,
  output logic [31:0]         o_io_top,
  input  wire logic           i_intx_level,
  output logic                o_intx_up,
  output logic [7:0]          o_intx_pin
);

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration checks.

  if (CFG_AW != 8) begin : g_bad_aw
    $error("bwh_bridge_window_regs: config address must be 8 bits");
  end

  // The readback packs neighbouring registers into one dword each, so the
  // offsets must keep sharing their dwords or the decode silently splits them.
  if ((`BWH_OFS_IO_TOP_HIGH >> 2) != (`BWH_OFS_IO_FLOOR_HIGH >> 2)) begin : g_bad_io_pair
    $error("bwh_bridge_window_regs: I/O upper halves must share one dword");
  end

  if (((`BWH_OFS_IRQ_PIN >> 2) != (`BWH_OFS_IRQ_LINE >> 2)) ||
      ((`BWH_OFS_BRIDGE_CTL >> 2) != (`BWH_OFS_IRQ_LINE >> 2))) begin : g_bad_irq_pair
    $error("bwh_bridge_window_regs: line, pin and bridge control must share one dword");
  end

  if ((`BWH_BCTL_OWN_W + `BWH_BCTL_ZERO_W != 16) ||
      (`BWH_BCTL_OWN_MSB + 1 != `BWH_BCTL_OWN_W)) begin : g_bad_bctl
    $error("bwh_bridge_window_regs: bridge control field split must cover 16 bits");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decode helpers.

  // True when the request falls in the dword that holds byte offset ofs.
  function automatic logic dw_match(input logic [7:0] addr, input logic [7:0] ofs);
    dw_match = (addr[7:2] == ofs[7:2]);
  endfunction : dw_match

  // Byte lane of a byte offset inside its dword.
  function automatic logic [1:0] lane_of(input logic [7:0] ofs);
    lane_of = ofs[1:0];
  endfunction : lane_of

  logic wr_req;
  logic rd_req;

  assign wr_req = i_cfg.valid && i_cfg.write;
  assign rd_req = i_cfg.valid && !i_cfg.write;

  logic sel_pref;
  logic sel_io;
  logic sel_cap;
  logic sel_irq;

  assign sel_pref = dw_match(i_cfg.addr, `BWH_OFS_PREF_TOP_HIGH);
  assign sel_io   = dw_match(i_cfg.addr, `BWH_OFS_IO_FLOOR_HIGH);
  assign sel_cap  = dw_match(i_cfg.addr, `BWH_OFS_CAP_HEAD);
  assign sel_irq  = dw_match(i_cfg.addr, `BWH_OFS_IRQ_LINE);

  //////////////////////////////////////////////////////////////////////////////
  // Writable storage.

  logic [31:0] pref_top_high;
  logic [15:0] io_floor_high;
  logic [15:0] io_top_high;
  logic [7:0]  irq_line;

  bwh_byte_reg #(
    .W   (32),
    .RST (`BWH_RST_PREF_TOP_HIGH)
  ) u_pref_top_high (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),                              // RULE2
    .i_we      (wr_req && sel_pref),                 // RULE1
    .i_be      (i_cfg.be),
    .i_wdata   (i_cfg.wdata),
    .o_q       (pref_top_high)
  );

  bwh_byte_reg #(
    .W   (16),
    .RST (`BWH_RST_IO_HIGH)
  ) u_io_floor_high (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),                              // RULE5
    .i_we      (wr_req && sel_io),                   // RULE3
    .i_be      (i_cfg.be[1:0]),
    .i_wdata   (i_cfg.wdata[15:0]),
    .o_q       (io_floor_high)
  );

  bwh_byte_reg #(
    .W   (16),
    .RST (`BWH_RST_IO_HIGH)
  ) u_io_top_high (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),                              // RULE5
    .i_we      (wr_req && sel_io),                   // RULE4
    .i_be      (i_cfg.be[3:2]),
    .i_wdata   (i_cfg.wdata[31:16]),
    .o_q       (io_top_high)
  );

  // The line byte is only remembered for software; only the config readback below reads it.
  bwh_byte_reg #(
    .W   (8),
    .RST (`BWH_RST_IRQ_LINE)
  ) u_irq_line (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),                              // RULE8
    .i_we      (wr_req && sel_irq),                  // RULE7
    .i_be      (i_cfg.be[lane_of(`BWH_OFS_IRQ_LINE)]),
    .i_wdata   (i_cfg.wdata[7:0]),
    .o_q       (irq_line)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Bridge control readback.

  // Bits 6:0 live in the neighbouring control logic and are only shown here.
  // Everything from bit 7 up is constant zero, so writes there are dropped.
  logic [15:0] bridge_ctl;

  assign bridge_ctl = {{`BWH_BCTL_ZERO_W{1'b0}},     // RULE12 RULE13 RULE14
                       i_bctl_low};                  // RULE11

  //////////////////////////////////////////////////////////////////////////////
  // Read data, registered.

  logic [31:0] rdata_nxt;
  logic        hit_nxt;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    hit_nxt   = 1'b1;
    if (sel_pref) begin
      rdata_nxt = pref_top_high;
    end else if (sel_io) begin
      rdata_nxt = {io_top_high, io_floor_high};
    end else if (sel_cap) begin
      rdata_nxt = {24'h00_0000, `BWH_VAL_CAP_HEAD};  // RULE6
    end else if (sel_irq) begin
      rdata_nxt = {bridge_ctl, `BWH_VAL_IRQ_PIN, irq_line}; // RULE9
    end else begin
      hit_nxt   = 1'b0;
    end
  end

  bwh_state_t state_r;
  bwh_state_t state_nxt;

  // Every request is answered one cycle later; a new one may follow at once.
  always_comb begin
    case (state_r)
      BWH_IDLE: state_nxt = i_cfg.valid ? BWH_RESP : BWH_IDLE;
      BWH_RESP: state_nxt = i_cfg.valid ? BWH_RESP : BWH_IDLE;
      default:  state_nxt = BWH_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_r <= BWH_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  logic [31:0] rdata_r;
  logic        hit_r;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rdata_r <= 32'h0000_0000;
      hit_r   <= 1'b0;
    end else if (i_cfg.valid) begin
      rdata_r <= rd_req ? rdata_nxt : 32'h0000_0000;
      hit_r   <= hit_nxt;
    end
  end

  assign o_cfg_ack   = (state_r == BWH_RESP);
  assign o_cfg_rdata = rdata_r;
  assign o_cfg_hit   = hit_r;

  //////////////////////////////////////////////////////////////////////////////
  // Window assembly.

  logic [63:0] pref_base;
  logic [63:0] pref_top;
  logic [31:0] io_base;
  logic [31:0] io_top;

  assign pref_base = {i_lower.pref_base_high, i_lower.pref_base_lo, `BWH_PREF_LOW_ZERO};
  assign pref_top  = {pref_top_high, i_lower.pref_limit_lo, `BWH_PREF_LOW_ONES}; // RULE15
  assign io_base   = {io_floor_high, i_lower.io_base_lo, `BWH_IO_LOW_ZERO};
  assign io_top    = {io_top_high, i_lower.io_limit_lo, `BWH_IO_LOW_ONES};

  // Registered copies give the downstream decode a clean timing start; they lag the fields by one cycle.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_pref_top <= 64'h0000_0000_0000_0000;
    end else begin
      o_pref_top <= pref_top;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_io_base  <= 32'h0000_0000;
      o_io_top   <= 32'h0000_0000;
    end else begin
      o_io_base  <= io_base;
      o_io_top   <= io_top;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Forwarding decision.

  logic in_pref;
  logic in_io;

  bwh_window_cmp #(
    .AW (64)
  ) u_cmp_pref (
    .i_addr   (i_fwd.addr),
    .i_base   (pref_base),
    .i_top    (pref_top),
    .o_inside (in_pref)
  );

  // I/O space is 32 bits wide; upper address bits are ignored for I/O.
  bwh_window_cmp #(
    .AW (32)
  ) u_cmp_io (
    .i_addr   (i_fwd.addr[31:0]),
    .i_base   (io_base),
    .i_top    (io_top),
    .o_inside (in_io)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_fwd_done <= 1'b0;
      o_fwd_hit  <= 1'b0;
    end else begin
      o_fwd_done <= i_fwd.valid;
      o_fwd_hit  <= i_fwd.valid && (i_fwd.is_io ? in_io : in_pref); // RULE16
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Legacy interrupt pass-through.

  // The level belongs to this bridge's primary side and keeps the fixed pin
  // code; no swizzle by device number is applied on the way upstream.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_intx_up  <= 1'b0;
      o_intx_pin <= 8'h00;
    end else begin
      o_intx_up  <= i_intx_level;                    // RULE10
      o_intx_pin <= `BWH_VAL_IRQ_PIN;                // RULE10
    end
  end

endmodule : bwh_bridge_window_regs

// File: src/bwh_defines.svh
`ifndef BWH_DEFINES_SVH
`define BWH_DEFINES_SVH

// Byte offsets of the registers in configuration space.
`define BWH_OFS_PREF_TOP_HIGH  8'h2c
`define BWH_OFS_IO_FLOOR_HIGH  8'h30
`define BWH_OFS_IO_TOP_HIGH    8'h32
`define BWH_OFS_CAP_HEAD       8'h34
`define BWH_OFS_IRQ_LINE       8'h3c
`define BWH_OFS_IRQ_PIN        8'h3d
`define BWH_OFS_BRIDGE_CTL     8'h3e

// Reset and fixed values.
`define BWH_RST_PREF_TOP_HIGH  32'h0000_0000
`define BWH_RST_IO_HIGH        16'h0000
`define BWH_VAL_CAP_HEAD       8'h50
`define BWH_RST_IRQ_LINE       8'hff
`define BWH_VAL_IRQ_PIN        8'h01
`define BWH_RST_BRIDGE_CTL     16'h0000

// Field layout of the bridge control word.
`define BWH_BCTL_OWN_MSB       6
`define BWH_BCTL_OWN_W         7
`define BWH_BCTL_ZERO_W        9

// Implied low bits of the assembled windows.
`define BWH_PREF_LOW_ONES      20'hf_ffff
`define BWH_PREF_LOW_ZERO      20'h0_0000
`define BWH_IO_LOW_ONES        12'hfff
`define BWH_IO_LOW_ZERO        12'h000

`endif

// File: src/bwh_pkg.sv
package bwh_pkg;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } bwh_cfg_req_t;

  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic [63:0] addr;
  } bwh_fwd_req_t;

  typedef struct packed {
    logic [11:0] pref_base_lo;
    logic [11:0] pref_limit_lo;
    logic [31:0] pref_base_high;
    logic [3:0]  io_base_lo;
    logic [3:0]  io_limit_lo;
  } bwh_lower_win_t;

  typedef enum logic [1:0] {
    BWH_IDLE = 2'b00,
    BWH_RESP = 2'b01
  } bwh_state_t;

endpackage : bwh_pkg

// File: src/bwh_byte_reg.sv
`timescale 1ns/100ps
module bwh_byte_reg #(
  parameter int         W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic           i_clk_sys,
  input  wire logic           i_rst,
  input  wire logic           i_we,
  input  wire logic [W/8-1:0] i_be,
  input  wire logic [W-1:0]   i_wdata,
  output logic      [W-1:0]   o_q
);

  if ((W % 8 != 0) || (W == 0)) begin : g_bad_w
    $error("bwh_byte_reg: width must be whole bytes");
  end

  // Each enabled byte lane is written on its own; others keep their value.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_q <= RST;
    end else if (i_we) begin
      for (int b = 0; b < W/8; b++) begin
        if (i_be[b]) begin
          o_q[b*8 +: 8] <= i_wdata[b*8 +: 8];
        end
      end
    end
  end

endmodule : bwh_byte_reg

// File: src/bwh_window_cmp.sv
`timescale 1ns/100ps
module bwh_window_cmp #(
  parameter int AW = 64
) (
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [AW-1:0] i_base,
  input  wire logic [AW-1:0] i_top,
  output logic               o_inside
);

  if (AW < 1) begin : g_bad_aw
    $error("bwh_window_cmp: address width must be positive");
  end

  // Both ends are inclusive; a base above the top gives an empty window.
  assign o_inside = (i_addr >= i_base) && (i_addr <= i_top); // RULE16

endmodule : bwh_window_cmp

// File: verif/bwh_bridge_window_regs_chk.sv
`timescale 1ns/100ps
module bwh_bridge_window_regs_chk
  import bwh_pkg::*;
(
  input wire logic           i_clk_sys,
  input wire logic           i_rst,
  input wire bwh_cfg_req_t   i_cfg,
  input wire logic           o_cfg_ack,
  input wire logic           o_cfg_hit,
  input wire logic [31:0]    o_cfg_rdata,
  input wire bwh_lower_win_t i_lower,
  input wire logic [6:0]     i_bctl_low,
  input wire bwh_fwd_req_t   i_fwd,
  input wire logic           o_fwd_done,
  input wire logic           o_fwd_hit,
  input wire logic [63:0]    o_pref_top,
  input wire logic [31:0]    o_io_base,
  input wire logic [31:0]    o_io_top,
  input wire logic           i_intx_level,
  input wire logic           o_intx_up,
  input wire logic [7:0]     o_intx_pin
);
  logic rd_34;
  logic rd_3c;
  assign rd_34 = i_cfg.valid && !i_cfg.write && i_cfg.addr[7:2] == 6'h0d;
  assign rd_3c = i_cfg.valid && !i_cfg.write && i_cfg.addr[7:2] == 6'h0f;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////
  chk_ack_timing: assert property (i_cfg.valid |=> o_cfg_ack) else $error("ack missing");
  chk_ack_cause: assert property (o_cfg_ack |-> $past(i_cfg.valid)) else $error("ack without request");
  chk_cap_fixed: assert property (rd_34 |=> o_cfg_hit && o_cfg_rdata[7:0] == 8'h50)
    else $error("capability pointer wrong");
  chk_pin_value: assert property (rd_3c |=> o_cfg_rdata[15:8] == 8'h01)
    else $error("interrupt pin wrong");
  chk_bctl_zero: assert property (rd_3c |=> o_cfg_rdata[31:23] == 9'h000)
    else $error("bridge control high bits set");
  chk_pref_asm: assert property (!$past(i_rst) |->
    o_pref_top[31:0] == {$past(i_lower.pref_limit_lo), 20'hf_ffff}) else $error("prefetch top wrong");
  chk_io_asm: assert property (!$past(i_rst) |-> o_io_top[15:0] == {$past(i_lower.io_limit_lo), 12'hfff}
    && o_io_base[15:0] == {$past(i_lower.io_base_lo), 12'h000}) else $error("io window wrong");
  chk_intx_pass: assert property (!$past(i_rst) |-> o_intx_up == $past(i_intx_level))
    else $error("interrupt not passed");
  chk_fwd_timing: assert property (i_fwd.valid |=> o_fwd_done) else $error("forward done missing");
  chk_fwd_hit_qual: assert property (o_fwd_hit |-> o_fwd_done) else $error("hit without done");
  chk_fwd_mem_win: assert property (o_fwd_done && !$past(i_fwd.is_io) |-> o_fwd_hit ==
    (($past(i_fwd.addr) >= {$past(i_lower.pref_base_high), $past(i_lower.pref_base_lo), 20'h0_0000})
     && ($past(i_fwd.addr) <= o_pref_top))) else $error("memory forward decision wrong");
  chk_fwd_io_win: assert property (o_fwd_done && $past(i_fwd.is_io) |-> o_fwd_hit ==
    (($past(i_fwd.addr[31:0]) >= o_io_base) && ($past(i_fwd.addr[31:0]) <= o_io_top)))
    else $error("io forward decision wrong");
  cover property (rd_3c);
  cover property (o_fwd_hit);
  cover property (i_cfg.valid && i_cfg.write ##1 i_cfg.valid);
endmodule : bwh_bridge_window_regs_chk

bind bwh_bridge_window_regs bwh_bridge_window_regs_chk u_chk (.*);

// File: verif/bwh_host_model.sv
`timescale 1ns/100ps
module bwh_host_model
  import bwh_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_ack,
  input  wire logic        i_hit,
  input  wire logic [31:0] i_rdata,
  output bwh_cfg_req_t     o_cfg
);
  initial o_cfg = '0;
  // Released fields flip so stale values are never mistaken for a request.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d,
                      output logic [31:0] rd, output logic h, output logic k);
    o_cfg = '{1'b1, w, a, b, d};
    @(negedge i_clk_sys);
    o_cfg = {1'b0, ~o_cfg[44:0]};
    rd = i_rdata;
    h = i_hit;
    k = i_ack;
    @(negedge i_clk_sys);
  endtask : xfer
endmodule : bwh_host_model

// File: verif/bwh_bridge_window_regs_tb_top.sv
`timescale 1ns/100ps
module bwh_bridge_window_regs_tb_top
  import bwh_pkg::*;
;
  logic clk, rst, ack, hit, done, fhit, intx, intx_up;
  logic [31:0] rdata, io_base, io_top;
  logic [63:0] pref_top;
  logic [7:0] pin;
  logic [6:0] bctl;
  bwh_cfg_req_t cfg;
  bwh_lower_win_t lower;
  bwh_fwd_req_t fwd;
  int mismatches, num_checks, cyc;

  bwh_host_model host (.i_clk_sys(clk), .i_ack(ack), .i_hit(hit), .i_rdata(rdata), .o_cfg(cfg));
  bwh_bridge_window_regs dut (.i_clk_sys(clk), .i_rst(rst), .i_cfg(cfg), .o_cfg_ack(ack), .o_cfg_hit(hit),
    .o_cfg_rdata(rdata), .i_lower(lower), .i_bctl_low(bctl), .i_fwd(fwd), .o_fwd_done(done),
    .o_fwd_hit(fhit), .o_pref_top(pref_top), .o_io_base(io_base), .o_io_top(io_top),
    .i_intx_level(intx), .o_intx_up(intx_up), .o_intx_pin(pin));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic eh);
    logic [31:0] d;
    logic h, k;
    host.xfer(1'b0, a, 4'h0, 32'h0, d, h, k);
    chk("rd_ack", k, 1'b1);
    chk("rdata", d, e);
    chk("hit", h, eh);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
    logic [31:0] d;
    logic h, k;
    host.xfer(1'b1, a, b, v, d, h, k);
    chk("wr_ack", k, 1'b1);
    chk("wr_rdata", d, 32'h0);
  endtask : wr
  task automatic fw(input logic io, input logic [63:0] a, input logic e);
    fwd = '{1'b1, io, a};
    @(negedge clk);
    fwd = {1'b0, ~fwd[64:0]};
    chk("fwd_done", done, 1'b1);
    chk("fwd_hit", fhit, e);
    @(negedge clk);
  endtask : fw
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // The ceiling sits far above the roughly 65 cycles the tests need.
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    rst = 1'b1;
    intx = 1'b0;
    bctl = 7'h5a;
    fwd = '0;
    lower = '{12'h100, 12'h1ff, 32'h0, 4'h0, 4'hf};
    repeat (12) @(negedge clk);
    rst = 1'b0;
    rd(8'h2c, 32'h0, 1'b1);
    rd(8'h30, 32'h0, 1'b1);
    rd(8'h34, 32'h50, 1'b1);
    rd(8'h3c, {9'h0, 7'h5a, 8'h01, 8'hff}, 1'b1);
    $display("test reset values done");
    wr(8'h2c, 4'hf, 32'hffff_ffff);
    rd(8'h2c, 32'hffff_ffff, 1'b1);
    wr(8'h2c, 4'hf, 32'h0000_0001);
    wr(8'h30, 4'h3, 32'hffff_1234);
    wr(8'h30, 4'hc, 32'h5678_ffff);
    rd(8'h30, 32'h5678_1234, 1'b1);
    wr(8'h34, 4'hf, 32'hffff_ffff);
    rd(8'h34, 32'h50, 1'b1);
    wr(8'h3c, 4'hf, 32'hffff_ffa5);
    rd(8'h3c, {9'h0, 7'h5a, 8'h01, 8'ha5}, 1'b1);
    rd(8'h38, 32'h0, 1'b0);
    $display("test registers done");
    chk("pref_top", pref_top, 64'h1_1fff_ffff);
    chk("io_base", io_base, 64'h1234_0000);
    chk("io_top", io_top, 64'h5678_ffff);
    fw(1'b0, 64'h0000_0000_1000_0000, 1'b1);
    fw(1'b0, 64'h0000_0000_0fff_ffff, 1'b0);
    fw(1'b0, 64'h0000_0001_1fff_ffff, 1'b1);
    fw(1'b0, 64'h0000_0001_2000_0000, 1'b0);
    fw(1'b1, 64'h1234_0000, 1'b1);
    fw(1'b1, 64'h1233_ffff, 1'b0);
    fw(1'b1, 64'h5678_ffff, 1'b1);
    fw(1'b1, 64'h5679_0000, 1'b0);
    intx = 1'b1;
    @(negedge clk);
    chk("intx_up", intx_up, 1'b1);
    chk("intx_pin", pin, 8'h01);
    $display("test forwarding done");
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(8'h3c, {9'h0, 7'h5a, 8'h01, 8'hff}, 1'b1);
    rd(8'h2c, 32'h0, 1'b1);
    $display("test second reset done");
    stop_test();
  end
endmodule : bwh_bridge_window_regs_tb_top
